/* File: core/clauth_cfg.svh */
// register offsets, field widths and codes, reset values and identity defaults
// assumes a 12-bit byte address within the port's management window
`ifndef CLAUTH_CFG_SVH
`define CLAUTH_CFG_SVH

`define CLAUTH_AW              12
`define CLAUTH_DW              32
`define CLAUTH_OFF_CLAIM_SET   12'hfa0
`define CLAUTH_OFF_CLAIM_CLR   12'hfa4
`define CLAUTH_OFF_PERM_STAT   12'hfb8
`define CLAUTH_OFF_ARCH_ID     12'hfbc
`define CLAUTH_CLAIM_W         2
`define CLAUTH_CLAIM_RST       2'h0
`define CLAUTH_CLAIM_IMPL      2'h3
`define CLAUTH_NPERM           6
`define CLAUTH_PERM_W          12
`define CLAUTH_PERM_RST        12'h000
`define CLAUTH_PERM_NONE       2'h0
`define CLAUTH_PERM_OFF        2'h2
`define CLAUTH_PERM_ON         2'h3
`define CLAUTH_ARCHITECT_DEF   11'h155
`define CLAUTH_ARCHITECTURE_ID_FIELD_DEF      16'h1234
`define CLAUTH_ARCH_PRESENT    1'h1
`define CLAUTH_ARCH_REV        4'h0
`define CLAUTH_ZERO32          32'h0000_0000

`endif

/* File: core/clauth_pkg.sv */
// shared types for the claim and permission register slice
// assumes the constants header is on the include path
`include "clauth_cfg.svh"

package clauth_pkg;

   typedef logic [`CLAUTH_AW-1:0]      clauth_addr_t;
   typedef logic [`CLAUTH_DW-1:0]      clauth_data_t;
   typedef logic [`CLAUTH_CLAIM_W-1:0] clauth_claim_t;
   typedef logic [`CLAUTH_PERM_W-1:0]  clauth_perm_t;

   typedef enum logic [1:0] {
      CLAUTH_SEL_NONE  = 2'h0,
      CLAUTH_SEL_SET   = 2'h1,
      CLAUTH_SEL_CLR   = 2'h3,
      CLAUTH_SEL_OTHER = 2'h2
   } clauth_sel_t;

endpackage

/* File: core/clauth_if.sv */
// internal carrier between the bus slave and its two register blocks
// assumes all three sit on pclk
`timescale 1ns/1ps

interface clauth_if;
   import clauth_pkg::*;

   logic          set_we;
   logic          clr_we;
   clauth_claim_t wbits;
   clauth_claim_t claim;
   clauth_perm_t  perm;

   modport regs  (output set_we, output clr_we, output wbits, input claim, input perm);
   modport claim_end (input set_we, input clr_we, input wbits, output claim);
   modport perm_end  (output perm);
endinterface

/* File: core/clauth_claim.sv */
// two-bit claim tag shared by the set and clear locations
// assumes one-cycle write strobes from the bus slave
`timescale 1ns/1ps
`include "clauth_cfg.svh"

module clauth_claim
   import clauth_pkg::*;
(
   input  wire logic  pclk,
   input  wire logic  presetn,
   clauth_if.claim_end cif
);

   clauth_claim_t claim_ff;
   clauth_claim_t nxt_claim;

   ////////////////////////////////////////////////////////////////////////////
   // set and clear of the token only

   always_comb begin
      nxt_claim = claim_ff;
      if (cif.set_we) begin
         nxt_claim = claim_ff | cif.wbits;
      end
      if (cif.clr_we) begin
         nxt_claim = claim_ff & ~cif.wbits;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         claim_ff <= `CLAUTH_CLAIM_RST;
      end else begin
         claim_ff <= nxt_claim;
      end
   end

   assign cif.claim = claim_ff;

endmodule

/* File: core/clauth_perm.sv */
// permission status: synchronises the pin inputs and encodes six fields
// assumes impl and en pins are asynchronous to pclk
`timescale 1ns/1ps
`include "clauth_cfg.svh"

module clauth_perm
   import clauth_pkg::*;
(
   input  wire logic                     pclk,
   input  wire logic                     presetn,
   input  wire logic [`CLAUTH_NPERM-1:0] perm_impl,
   input  wire logic [`CLAUTH_NPERM-1:0] perm_en,
   clauth_if.perm_end                    cif
);

   logic [2*`CLAUTH_NPERM-1:0] meta_ff;
   logic [2*`CLAUTH_NPERM-1:0] sync_ff;
   logic [2*`CLAUTH_NPERM-1:0] nxt_meta;
   logic [2*`CLAUTH_NPERM-1:0] nxt_sync;
   clauth_perm_t               perm_ff;
   clauth_perm_t               nxt_perm;

   // never yields the reserved code
   function automatic logic [1:0] perm_code(input logic impl, input logic en);
      if (!impl) begin
         perm_code = `CLAUTH_PERM_NONE;
      end else if (en) begin
         perm_code = `CLAUTH_PERM_ON;
      end else begin
         perm_code = `CLAUTH_PERM_OFF;
      end
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // two-flop synchroniser then encode

   always_comb begin
      nxt_meta = {perm_impl, perm_en};
      nxt_sync = meta_ff;
      nxt_perm = `CLAUTH_PERM_RST;
      for (int i = 0; i < `CLAUTH_NPERM; i++) begin
         nxt_perm[2*i +: 2] = perm_code(sync_ff[`CLAUTH_NPERM+i], sync_ff[i]);
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         meta_ff <= {`CLAUTH_PERM_RST};
         sync_ff <= {`CLAUTH_PERM_RST};
         perm_ff <= `CLAUTH_PERM_RST;
      end else begin
         meta_ff <= nxt_meta;
         sync_ff <= nxt_sync;
         perm_ff <= nxt_perm;
      end
   end

   assign cif.perm = perm_ff;

endmodule

/* File: core/clauth_top.sv */
// apb slave for claim tag, permission status and architecture identity
// assumes a zero-wait apb master on pclk; perm pins are asynchronous
//
// Implementation choice: register access over APB.
`timescale 1ns/1ps
`include "clauth_cfg.svh"

module clauth_top
   import clauth_pkg::*;
#(
   parameter logic [10:0] ARCHITECT = `CLAUTH_ARCHITECT_DEF, // arbitrary value
   parameter logic [15:0] ARCH_ID   = `CLAUTH_ARCHITECTURE_ID_FIELD_DEF     // arbitrary value
)
(
   input  wire logic                     pclk,
   input  wire logic                     presetn,
   input  wire logic                     psel,
   input  wire logic                     penable,
   input  wire logic                     pwrite,
   input  wire logic [`CLAUTH_AW-1:0]    paddr,
   input  wire logic [`CLAUTH_DW-1:0]    pwdata,
   output      logic [`CLAUTH_DW-1:0]    prdata,
   output      logic                     pready,
   output      logic                     pslverr,
   input  wire logic [`CLAUTH_NPERM-1:0] perm_impl,
   input  wire logic [`CLAUTH_NPERM-1:0] perm_en,
   output      logic [`CLAUTH_CLAIM_W-1:0] claim_tag
);

   clauth_if     cif ();
   clauth_data_t rdata_ff;
   clauth_data_t nxt_rdata;
   logic         err_ff;
   logic         nxt_err;
   logic         setup;
   logic         access;
   clauth_sel_t  wsel;

   // word decode shared by read and write paths
   function automatic logic hit(input clauth_addr_t a, input clauth_addr_t off);
      hit = (a[`CLAUTH_AW-1:2] == off[`CLAUTH_AW-1:2]);
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // phases and write strobes

   assign setup  = psel & ~penable;
   assign access = psel & penable;
   assign pready = 1'b1;

   always_comb begin
      wsel = CLAUTH_SEL_NONE;
      if (access && pwrite) begin
         if (hit(paddr, `CLAUTH_OFF_CLAIM_SET)) begin
            wsel = CLAUTH_SEL_SET;
         end else if (hit(paddr, `CLAUTH_OFF_CLAIM_CLR)) begin
            wsel = CLAUTH_SEL_CLR;
         end else begin
            wsel = CLAUTH_SEL_OTHER;
         end
      end
   end

   assign cif.set_we = (wsel == CLAUTH_SEL_SET);
   assign cif.clr_we = (wsel == CLAUTH_SEL_CLR);
   assign cif.wbits  = pwdata[`CLAUTH_CLAIM_W-1:0];

   ////////////////////////////////////////////////////////////////////////////
   // read data and error, captured in the setup cycle

   always_comb begin
      nxt_rdata = rdata_ff;
      nxt_err   = err_ff;
      if (setup) begin
         nxt_rdata = `CLAUTH_ZERO32;
         nxt_err   = 1'b0;
         if (hit(paddr, `CLAUTH_OFF_CLAIM_SET)) begin
            nxt_rdata[`CLAUTH_CLAIM_W-1:0] = `CLAUTH_CLAIM_IMPL;
         end else if (hit(paddr, `CLAUTH_OFF_CLAIM_CLR)) begin
            nxt_rdata[`CLAUTH_CLAIM_W-1:0] = cif.claim;
         end else if (hit(paddr, `CLAUTH_OFF_PERM_STAT)) begin
            if (!pwrite) begin
               nxt_rdata[`CLAUTH_PERM_W-1:0] = cif.perm;
            end
         end else if (hit(paddr, `CLAUTH_OFF_ARCH_ID)) begin
            if (!pwrite) begin
               nxt_rdata = {ARCHITECT, `CLAUTH_ARCH_PRESENT, `CLAUTH_ARCH_REV, ARCH_ID};
            end
         end else begin
            nxt_err = 1'b1;
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rdata_ff <= `CLAUTH_ZERO32;
         err_ff   <= 1'b0;
      end else begin
         rdata_ff <= nxt_rdata;
         err_ff   <= nxt_err;
      end
   end

   assign prdata    = rdata_ff;
   assign pslverr   = access & err_ff;
   assign claim_tag = cif.claim;

   ////////////////////////////////////////////////////////////////////////////
   // register blocks

   clauth_claim u_claim (
      .pclk    (pclk),
      .presetn (presetn),
      .cif     (cif.claim_end)
   );

   clauth_perm u_perm (
      .pclk      (pclk),
      .presetn   (presetn),
      .perm_impl (perm_impl),
      .perm_en   (perm_en),
      .cif       (cif.perm_end)
   );

endmodule

/* File: bench/clauth_asserts.sv */
// concurrent checks on the ports of clauth_top
// assumes zero-wait apb on pclk, bound from the bench
`timescale 1ns/1ps
`include "clauth_cfg.svh"

module clauth_asserts #(
   parameter logic [10:0] ARCHITECT = 11'h0,
   parameter logic [15:0] ARCH_ID   = 16'h0
) (
   input wire logic        pclk,
   input wire logic        presetn,
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic        pready,
   input wire logic        pslverr,
   input wire logic [5:0]  perm_impl,
   input wire logic [5:0]  perm_en,
   input wire logic [1:0]  claim_tag
);
   ////////////////////////////////
   logic [11:0] wa;
   logic        mapped;
   logic        wr_claim;
   assign wa = {paddr[11:2], 2'h0};
   assign mapped = wa inside {`CLAUTH_OFF_CLAIM_SET, `CLAUTH_OFF_CLAIM_CLR,
                              `CLAUTH_OFF_PERM_STAT, `CLAUTH_OFF_ARCH_ID};
   assign wr_claim = psel & penable & pwrite &
                     (wa inside {`CLAUTH_OFF_CLAIM_SET, `CLAUTH_OFF_CLAIM_CLR});

   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);

   sequence s_rd(logic [11:0] a);
      psel && !penable && !pwrite && wa == a;
   endsequence
   sequence s_wr(logic [11:0] a);
      psel && penable && pwrite && wa == a;
   endsequence

   ////////////////////////////////
   clr_write_a:
      assert property (s_wr(`CLAUTH_OFF_CLAIM_CLR) |=>
         claim_tag == ($past(claim_tag) & ~$past(pwdata[1:0])))
      else $error("claim clear write wrong");
   set_write_a:
      assert property (s_wr(`CLAUTH_OFF_CLAIM_SET) |=>
         claim_tag == ($past(claim_tag) | $past(pwdata[1:0])))
      else $error("claim set write wrong");
   claim_hold_a:
      assert property (!wr_claim |=> $stable(claim_tag))
      else $error("claim changed without write");
   clr_read_a:
      assert property (s_rd(`CLAUTH_OFF_CLAIM_CLR) |=> prdata == {30'h0, $past(claim_tag)})
      else $error("claim read wrong");
   set_read_a:
      assert property (s_rd(`CLAUTH_OFF_CLAIM_SET) |=> prdata == 32'h3)
      else $error("claim set read wrong");
   arch_read_a:
      assert property (s_rd(`CLAUTH_OFF_ARCH_ID) |=>
         prdata == {ARCHITECT, 1'h1, 4'h0, ARCH_ID})
      else $error("identity read wrong");
   perm_code_a:
      assert property (s_rd(`CLAUTH_OFF_PERM_STAT) |=> prdata[31:12] == 20'h0 &&
         (((~prdata[11:0]) >> 1) & prdata[11:0] & 12'h555) == 12'h0)
      else $error("permission read wrong");
   map_error_a:
      assert property (psel && penable |-> pready && pslverr == !mapped)
      else $error("error response wrong");
endmodule

/* File: bench/clauth_top_tb.sv */
// self-checking bench for clauth_top
// assumes design files and checker compiled first
`timescale 1ns/1ps

module clauth_top_tb;
   localparam logic [10:0] ARCHT = 11'h2aa;  // arbitrary value
   localparam logic [15:0] AID   = 16'h5a5a; // arbitrary value
   logic        pclk = 1'h0, presetn = 1'h0, psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
   logic [11:0] paddr = 12'h0;
   logic [31:0] pwdata = 32'h0, prdata, rd;
   logic        pready, pslverr, er;
   logic [5:0]  perm_impl = 6'h2d, perm_en = 6'h26;
   logic [1:0]  claim_tag;
   int          mismatches = 0, checks_done = 0;
   // write, error, address, data or expected read
   logic [45:0] rows [18] = '{
      {2'h0, 12'hfa4, 32'h0}, {2'h2, 12'hfa0, 32'hffff_fffd}, {2'h0, 12'hfa4, 32'h1},
      {2'h2, 12'hfa0, 32'h2}, {2'h0, 12'hfa4, 32'h3}, {2'h2, 12'hfa4, 32'hffff_fffe},
      {2'h0, 12'hfa4, 32'h1}, {2'h2, 12'hfa4, 32'h1}, {2'h0, 12'hfa4, 32'h0},
      {2'h2, 12'hfa0, 32'h3}, {2'h0, 12'hfa0, 32'h3}, {2'h2, 12'hfb8, 32'hffff_ffff},
      {2'h0, 12'hfb8, 32'hcb2}, {2'h2, 12'hfbc, 32'h0},
      {2'h0, 12'hfbc, ARCHT, 1'h1, 4'h0, AID}, {2'h1, 12'h000, 32'h0},
      {2'h3, 12'hffc, 32'h0}, {2'h0, 12'hfa4, 32'h3}};

   clauth_top #(.ARCHITECT(ARCHT), .ARCH_ID(AID)) u_dut (
      .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .perm_impl(perm_impl), .perm_en(perm_en), .claim_tag(claim_tag));

   always #20 pclk = ~pclk;

   ////////////////////////////////
   task automatic chk_val(input logic [31:0] got, input logic [31:0] exp);
      checks_done++;
      if (got !== exp) begin
         mismatches++;
         $display("[FAIL] %0t got %h exp %h", $time, got, exp);
      end
   endtask

   task automatic chk_flag(input logic got, input logic exp);
      chk_val({31'h0, got}, {31'h0, exp});
   endtask

   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'h1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'h1;
      do begin
         @(posedge pclk);
      end while (pready !== 1'h1);
      rd = prdata;
      er = pslverr;
      psel <= 1'h0;
      penable <= 1'h0;
   endtask

   task automatic finish_test;
      if (mismatches == 0 && checks_done > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask

   ////////////////////////////////
   initial begin
      repeat (16) @(posedge pclk);
      presetn <= 1'h1;
      foreach (rows[i]) begin
         apb(rows[i][45], rows[i][43:32], rows[i][31:0]);
         if (!rows[i][45]) chk_val(rd, rows[i][31:0]);
         chk_flag(er, rows[i][44]);
      end
      chk_val({30'h0, claim_tag}, 32'h3);
      @(posedge pclk);
      perm_impl <= 6'h3f;
      perm_en <= 6'h00;
      repeat (3) @(posedge pclk);
      apb(1'h0, 12'hfb8, 32'h0);
      chk_val(rd, 32'haaa);
      @(posedge pclk);
      presetn <= 1'h0;
      @(posedge pclk);
      chk_val({30'h0, claim_tag}, 32'h0);
      presetn <= 1'h1;
      apb(1'h0, 12'hfa4, 32'h0);
      chk_val(rd, 32'h0);
      finish_test();
   end

   initial begin
      repeat (3000) @(posedge pclk);
      mismatches++;
      finish_test();
   end
endmodule

bind clauth_top clauth_asserts #(.ARCHITECT(ARCHITECT), .ARCH_ID(ARCH_ID)) u_chk (
   .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
   .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
   .perm_impl(perm_impl), .perm_en(perm_en), .claim_tag(claim_tag));
